// ===== rtl/aiex_pkg.sv
// Shared constants, types and register map of the accumulator instruction executor
package aiex_pkg;

   // Instruction groups handled by the executor
   typedef enum logic [4:0] {
      OP_IDLE,
      OP_COPY_TO_ACC,
      OP_LOAD_IMM,
      OP_STORE_ACC,
      OP_OR_MEM,
      OP_OR_IMM,
      OP_DISJ_TO_MEM,
      OP_CALL,
      OP_SUB_EXIT,
      OP_SUB_EXIT_IMM,
      OP_IRQ_EXIT,
      OP_ROT_LEFT,
      OP_ROT_LEFT_TO_ACC,
      OP_ROT_LEFT_VIA_CARRY,
      OP_ROT_LEFT_VIA_CARRY_TO_ACC,
      OP_ROT_RIGHT,
      OP_ROT_RIGHT_TO_ACC,
      OP_ROT_RIGHT_VIA_CARRY,
      OP_ROT_RIGHT_VIA_CARRY_TO_ACC,
      OP_SUB_BORROW,
      OP_SUB_BORROW_TO_MEM,
      OP_DEC_SKIP_ZERO
   } aiex_op_t;

   // Decoded instruction as delivered by the fetch path
   typedef struct packed {
      aiex_op_t op;
      logic [4:0] addr;
      logic [9:0] target;
      logic [7:0] imm;
   } aiex_instr_t;

   // Arithmetic status flags
   typedef struct packed {
      logic signed_range_exceeded;
      logic zero;
      logic half_carry;
      logic carry;
   } aiex_flags_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_EXEC,
      ST_SECOND,
      ST_DUMMY
   } aiex_state_t;

   // APB register byte addresses
   localparam logic [7:0] REG_ACC = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PC = 8'h08;
   localparam logic [7:0] REG_STACK = 8'h0c;
   localparam logic [7:0] REG_CTRL = 8'h10;

   // Status register field positions
   localparam int BIT_CARRY = 0;
   localparam int BIT_HALF = 1;
   localparam int BIT_ZERO = 2;
   localparam int BIT_SIGNED = 3;
   localparam int BIT_GIE = 4;
   localparam int BIT_BUSY = 5;
   // Control register field position
   localparam int BIT_RUN = 0;

   // Reset values
   localparam logic [7:0] RST_ACC = 8'h00;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic RST_GIE = 1'b0;
   localparam logic RST_RUN = 1'b0;
   localparam logic [9:0] RST_PC = 10'h000;

endpackage : aiex_pkg

// ===== rtl/aiex_dmem.sv
// Data memory with one combinational read port and one clocked write port
`timescale 1ns/10ps
module aiex_dmem #(
   parameter int DEPTH = 32,
   parameter int AW = 5,
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Read is combinational so an operand is ready in the execute cycle
   assign rdata = mem[raddr];

   // Write lands at the clock edge that ends the execute cycle
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

endmodule : aiex_dmem

// ===== rtl/aiex_core.sv
// Accumulator instruction executor with APB register access
// Summary of operation
// - Copy-to-accumulator loads the addressed memory byte; memory and flags unchanged.
// - Load-immediate writes the 8-bit constant to the accumulator; flags unchanged.
// - Store-accumulator writes the accumulator to memory; flags unchanged.
// - Idle instruction only advances the program counter by one.
// - OR with memory or immediate goes to accumulator; only zero flag updates.
// - Disjunction-to-memory ORs and writes back to memory; only zero flag updates.
// - Subroutine exit reloads program counter from stack; two cycles; no flags.
// - Exit-with-constant reloads program counter and loads immediate into accumulator.
// - Interrupt exit reloads program counter and sets global interrupt enable.
// - Rotate left wraps bit 7 into bit 0; memory or accumulator; no flags.
// - Rotate left via carry: bit 7 to carry, old carry to bit 0.
// - Rotate right wraps bit 0 into bit 7; memory or accumulator; no flags.
// - Rotate right via carry: bit 0 to carry, old carry to bit 7.
// - Subtract with borrow is acc plus inverted memory plus carry; four flags.
// - Decrement-skip-zero writes back; zero result skips using two cycles.
// - A taken skip discards the prefetched instruction and inserts a dummy cycle.
// - Call pushes the address after the call onto the return stack.
`timescale 1ns/10ps
module aiex_core #(
   parameter int PCW = 10,
   parameter int MEM_DEPTH = 32,
   parameter int MEM_AW = 5
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_valid,
   input wire aiex_pkg::aiex_instr_t instr,
   output logic instr_ready,
   output logic [PCW-1:0] pc,
   output logic discard_prefetch,
   output logic global_irq_enable
);

   logic [7:0] acc, next_acc;
   aiex_pkg::aiex_flags_t flags, next_flags;
   logic next_gie;
   logic [PCW-1:0] next_pc;
   logic [PCW-1:0] stack, next_stack;
   logic run, next_run;
   aiex_pkg::aiex_state_t state, next_state;
   logic next_discard;
   logic [31:0] next_prdata;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;
   logic fire;
   logic apb_access;
   logic mapped;
   logic [8:0] diff;
   logic [4:0] diff_low;
   logic [7:0] nmem;
   logic [7:0] dec;

   // Operand storage
   aiex_dmem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW), .WIDTH(8)) u_dmem (
      .mclk(mclk),
      .raddr(instr.addr[MEM_AW-1:0]),
      .rdata(mem_rdata),
      .we(mem_we),
      .waddr(instr.addr[MEM_AW-1:0]),
      .wdata(mem_wdata)
   );

   // Instructions are taken only in the execute state while running
   assign instr_ready = run && (state == aiex_pkg::ST_EXEC);
   assign fire = instr_valid && instr_ready;
   assign apb_access = psel && penable;
   assign pready = 1'b1;
   assign mapped = (paddr == aiex_pkg::REG_ACC) || (paddr == aiex_pkg::REG_STATUS) ||
                   (paddr == aiex_pkg::REG_PC) || (paddr == aiex_pkg::REG_STACK) ||
                   (paddr == aiex_pkg::REG_CTRL);
   assign pslverr = apb_access && !mapped;

   // Arithmetic helpers for borrow subtract and decrement
   assign nmem = ~mem_rdata;
   assign diff = {1'b0, acc} + {1'b0, nmem} + {8'h00, flags.carry};
   assign diff_low = {1'b0, acc[3:0]} + {1'b0, nmem[3:0]} + {4'h0, flags.carry};
   assign dec = mem_rdata - 8'h01;

   // Execution, sequencing and software register writes
   always_comb begin
      next_acc = acc;
      next_flags = flags;
      next_gie = global_irq_enable;
      next_pc = pc;
      next_stack = stack;
      next_run = run;
      next_state = aiex_pkg::ST_EXEC;
      next_discard = 1'b0;
      mem_we = 1'b0;
      mem_wdata = acc;
      // Software writes; an executing instruction below overrides them
      if (apb_access && pwrite) begin
         unique case (paddr)
            aiex_pkg::REG_ACC: next_acc = pwdata[7:0];
            aiex_pkg::REG_STATUS: begin
               next_flags.carry = pwdata[aiex_pkg::BIT_CARRY];
               next_flags.half_carry = pwdata[aiex_pkg::BIT_HALF];
               next_flags.zero = pwdata[aiex_pkg::BIT_ZERO];
               next_flags.signed_range_exceeded = pwdata[aiex_pkg::BIT_SIGNED];
               next_gie = pwdata[aiex_pkg::BIT_GIE];
            end
            aiex_pkg::REG_CTRL: next_run = pwdata[aiex_pkg::BIT_RUN];
            default: begin
            end
         endcase
      end
      if (fire) begin
         next_pc = pc + PCW'(1);
         unique case (instr.op)
            aiex_pkg::OP_IDLE: begin
            end
            aiex_pkg::OP_COPY_TO_ACC: next_acc = mem_rdata;
            aiex_pkg::OP_LOAD_IMM: next_acc = instr.imm;
            aiex_pkg::OP_STORE_ACC: begin
               mem_we = 1'b1;
               mem_wdata = acc;
            end
            aiex_pkg::OP_OR_MEM: begin
               next_acc = acc | mem_rdata;
               next_flags.zero = ((acc | mem_rdata) == 8'h00);
            end
            aiex_pkg::OP_OR_IMM: begin
               next_acc = acc | instr.imm;
               next_flags.zero = ((acc | instr.imm) == 8'h00);
            end
            aiex_pkg::OP_DISJ_TO_MEM: begin
               mem_we = 1'b1;
               mem_wdata = acc | mem_rdata;
               next_flags.zero = ((acc | mem_rdata) == 8'h00);
            end
            aiex_pkg::OP_CALL: begin
               next_stack = pc + PCW'(1);
               next_pc = PCW'(instr.target);
               next_state = aiex_pkg::ST_SECOND;
            end
            aiex_pkg::OP_SUB_EXIT: begin
               next_pc = stack;
               next_state = aiex_pkg::ST_SECOND;
            end
            aiex_pkg::OP_SUB_EXIT_IMM: begin
               next_pc = stack;
               next_acc = instr.imm;
               next_state = aiex_pkg::ST_SECOND;
            end
            aiex_pkg::OP_IRQ_EXIT: begin
               next_pc = stack;
               next_gie = 1'b1;
               next_state = aiex_pkg::ST_SECOND;
            end
            aiex_pkg::OP_ROT_LEFT: begin
               mem_we = 1'b1;
               mem_wdata = {mem_rdata[6:0], mem_rdata[7]};
            end
            aiex_pkg::OP_ROT_LEFT_TO_ACC: next_acc = {mem_rdata[6:0], mem_rdata[7]};
            aiex_pkg::OP_ROT_LEFT_VIA_CARRY: begin
               mem_we = 1'b1;
               mem_wdata = {mem_rdata[6:0], flags.carry};
               next_flags.carry = mem_rdata[7];
            end
            aiex_pkg::OP_ROT_LEFT_VIA_CARRY_TO_ACC: begin
               next_acc = {mem_rdata[6:0], flags.carry};
               next_flags.carry = mem_rdata[7];
            end
            aiex_pkg::OP_ROT_RIGHT: begin
               mem_we = 1'b1;
               mem_wdata = {mem_rdata[0], mem_rdata[7:1]};
            end
            aiex_pkg::OP_ROT_RIGHT_TO_ACC: next_acc = {mem_rdata[0], mem_rdata[7:1]};
            aiex_pkg::OP_ROT_RIGHT_VIA_CARRY: begin
               mem_we = 1'b1;
               mem_wdata = {flags.carry, mem_rdata[7:1]};
               next_flags.carry = mem_rdata[0];
            end
            aiex_pkg::OP_ROT_RIGHT_VIA_CARRY_TO_ACC: begin
               next_acc = {flags.carry, mem_rdata[7:1]};
               next_flags.carry = mem_rdata[0];
            end
            aiex_pkg::OP_SUB_BORROW, aiex_pkg::OP_SUB_BORROW_TO_MEM: begin
               if (instr.op == aiex_pkg::OP_SUB_BORROW) begin
                  next_acc = diff[7:0];
               end else begin
                  mem_we = 1'b1;
                  mem_wdata = diff[7:0];
               end
               next_flags.carry = diff[8];
               next_flags.half_carry = diff_low[4];
               next_flags.zero = (diff[7:0] == 8'h00);
               next_flags.signed_range_exceeded = (acc[7] == nmem[7]) && (diff[7] != acc[7]);
            end
            aiex_pkg::OP_DEC_SKIP_ZERO: begin
               mem_we = 1'b1;
               mem_wdata = dec;
               if (dec == 8'h00) begin
                  next_pc = pc + PCW'(2);
                  next_discard = 1'b1;
                  next_state = aiex_pkg::ST_DUMMY;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is registered during the setup cycle
   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         aiex_pkg::REG_ACC: next_prdata[7:0] = acc;
         aiex_pkg::REG_STATUS: begin
            next_prdata[aiex_pkg::BIT_CARRY] = flags.carry;
            next_prdata[aiex_pkg::BIT_HALF] = flags.half_carry;
            next_prdata[aiex_pkg::BIT_ZERO] = flags.zero;
            next_prdata[aiex_pkg::BIT_SIGNED] = flags.signed_range_exceeded;
            next_prdata[aiex_pkg::BIT_GIE] = global_irq_enable;
            next_prdata[aiex_pkg::BIT_BUSY] = (state != aiex_pkg::ST_EXEC);
         end
         aiex_pkg::REG_PC: next_prdata[PCW-1:0] = pc;
         aiex_pkg::REG_STACK: next_prdata[PCW-1:0] = stack;
         aiex_pkg::REG_CTRL: next_prdata[aiex_pkg::BIT_RUN] = run;
         default: begin
         end
      endcase
      if (!(psel && !penable && !pwrite)) begin
         next_prdata = prdata;
      end
   end

   // State registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         acc <= aiex_pkg::RST_ACC;
         flags <= aiex_pkg::RST_FLAGS;
         global_irq_enable <= aiex_pkg::RST_GIE;
         pc <= aiex_pkg::RST_PC;
         stack <= aiex_pkg::RST_PC;
         run <= aiex_pkg::RST_RUN;
         state <= aiex_pkg::ST_EXEC;
         discard_prefetch <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         acc <= next_acc;
         flags <= next_flags;
         global_irq_enable <= next_gie;
         pc <= next_pc;
         stack <= next_stack;
         run <= next_run;
         state <= next_state;
         discard_prefetch <= next_discard;
         prdata <= next_prdata;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_copy_flags_kept: assert property (
      fire && instr.op == aiex_pkg::OP_COPY_TO_ACC && !(apb_access && pwrite)
      |=> acc == $past(mem_rdata) && flags == $past(flags))
      else $error("copy to accumulator wrong");
   a_load_imm_acc: assert property (
      fire && instr.op == aiex_pkg::OP_LOAD_IMM && !(apb_access && pwrite)
      |=> acc == $past(instr.imm) && flags == $past(flags))
      else $error("immediate load wrong");
   a_store_mem_write: assert property (
      fire && instr.op == aiex_pkg::OP_STORE_ACC |-> mem_we && mem_wdata == acc)
      else $error("store did not write accumulator");
   a_idle_pc_step: assert property (
      fire && instr.op == aiex_pkg::OP_IDLE && !(apb_access && pwrite)
      |=> pc == $past(pc) + PCW'(1) && acc == $past(acc) && flags == $past(flags))
      else $error("idle did more than step");
   a_or_zero_flag: assert property (
      fire && instr.op == aiex_pkg::OP_OR_IMM
      |=> acc == ($past(acc) | $past(instr.imm)) && flags.zero == (acc == 8'h00))
      else $error("or immediate result wrong");
   a_exit_two_cycles: assert property (
      fire && instr.op == aiex_pkg::OP_SUB_EXIT |=> pc == $past(stack) && !instr_ready ##1 instr_ready || !run)
      else $error("exit timing wrong");
   a_irq_exit_gie: assert property (
      fire && instr.op == aiex_pkg::OP_IRQ_EXIT |=> global_irq_enable && pc == $past(stack))
      else $error("interrupt exit did not enable");
   a_rot_left_carry: assert property (
      fire && instr.op == aiex_pkg::OP_ROT_LEFT_VIA_CARRY_TO_ACC
      |=> flags.carry == $past(mem_rdata[7]) && acc == {$past(mem_rdata[6:0]), $past(flags.carry)})
      else $error("left carry rotate wrong");
   a_skip_dummy: assert property (
      fire && instr.op == aiex_pkg::OP_DEC_SKIP_ZERO && mem_rdata == 8'h01
      |=> discard_prefetch && !instr_ready && pc == $past(pc) + PCW'(2) ##1 !discard_prefetch)
      else $error("skip did not insert dummy cycle");
   a_dec_no_skip: assert property (
      fire && instr.op == aiex_pkg::OP_DEC_SKIP_ZERO && mem_rdata != 8'h01 && !(apb_access && pwrite)
      |=> instr_ready && !discard_prefetch && pc == $past(pc) + PCW'(1) && flags == $past(flags))
      else $error("untaken decrement skip wrong");
   a_call_push: assert property (
      fire && instr.op == aiex_pkg::OP_CALL |=> stack == $past(pc) + PCW'(1) && pc == $past(instr.target))
      else $error("call push wrong");

endmodule : aiex_core

// ===== test/accumulator_instruction_exec_bench.sv
// Self-checking bench for the accumulator instruction executor
`timescale 1ns/10ps
module accumulator_instruction_exec_bench;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, w;
   logic instr_valid, instr_ready, discard_prefetch, global_irq_enable;
   aiex_pkg::aiex_instr_t instr;
   logic [9:0] pc, pc_m, stk_m;
   logic [7:0] acc_m;
   logic [7:0] mem_m [32];
   logic c_m, h_m, z_m, v_m, g_m;
   logic [32:0] note_q [$];
   int n_errors = 0;
   int checks = 0;
   int seed = 32'h9ea6;

   aiex_core #(.PCW(10), .MEM_DEPTH(32), .MEM_AW(5)) dut (
      .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
      .instr(instr), .instr_ready(instr_ready), .pc(pc), .discard_prefetch(discard_prefetch),
      .global_irq_enable(global_irq_enable)
   );

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Read with the expected {error, data} noted first
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      note_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Offer one instruction, then count stall cycles and note any discard pulse
   task automatic exec(input aiex_pkg::aiex_instr_t x, output int n, output logic d);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr <= x;
      do @(posedge mclk); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      n = 0;
      d = 1'b0;
      forever begin
         @(posedge mclk);
         d = d | discard_prefetch;
         if (instr_ready === 1'b1) break;
         n++;
      end
   endtask : exec

   // Reference behaviour of one instruction
   task automatic model(input aiex_pkg::aiex_instr_t x, output int n, output logic d);
      logic [7:0] m;
      logic [7:0] r;
      logic [8:0] s;
      logic [4:0] h;
      m = mem_m[x.addr];
      r = m;
      s = {1'b0, acc_m} + {1'b0, ~m} + {8'h00, c_m};
      h = {1'b0, acc_m[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c_m};
      n = 0;
      d = 1'b0;
      pc_m = pc_m + 10'h001;
      case (x.op)
         aiex_pkg::OP_COPY_TO_ACC: acc_m = m;
         aiex_pkg::OP_LOAD_IMM: acc_m = x.imm;
         aiex_pkg::OP_STORE_ACC: mem_m[x.addr] = acc_m;
         aiex_pkg::OP_OR_MEM, aiex_pkg::OP_DISJ_TO_MEM: r = acc_m | m;
         aiex_pkg::OP_OR_IMM: r = acc_m | x.imm;
         aiex_pkg::OP_CALL: begin
            stk_m = pc_m;
            pc_m = x.target;
            n = 1;
         end
         aiex_pkg::OP_SUB_EXIT, aiex_pkg::OP_SUB_EXIT_IMM, aiex_pkg::OP_IRQ_EXIT: begin
            pc_m = stk_m;
            n = 1;
         end
         aiex_pkg::OP_ROT_LEFT, aiex_pkg::OP_ROT_LEFT_TO_ACC: r = {m[6:0], m[7]};
         aiex_pkg::OP_ROT_LEFT_VIA_CARRY, aiex_pkg::OP_ROT_LEFT_VIA_CARRY_TO_ACC: begin
            r = {m[6:0], c_m};
            c_m = m[7];
         end
         aiex_pkg::OP_ROT_RIGHT, aiex_pkg::OP_ROT_RIGHT_TO_ACC: r = {m[0], m[7:1]};
         aiex_pkg::OP_ROT_RIGHT_VIA_CARRY, aiex_pkg::OP_ROT_RIGHT_VIA_CARRY_TO_ACC: begin
            r = {c_m, m[7:1]};
            c_m = m[0];
         end
         aiex_pkg::OP_SUB_BORROW, aiex_pkg::OP_SUB_BORROW_TO_MEM: begin
            r = s[7:0];
            v_m = (acc_m[7] == ~m[7]) && (r[7] != acc_m[7]);
            h_m = h[4];
            c_m = s[8];
         end
         aiex_pkg::OP_DEC_SKIP_ZERO: begin
            r = m - 8'h01;
            n = (r == 8'h00) ? 1 : 0;
         end
         default: ;
      endcase
      if (x.op == aiex_pkg::OP_SUB_EXIT_IMM) acc_m = x.imm;
      if (x.op == aiex_pkg::OP_IRQ_EXIT) g_m = 1'b1;
      if (x.op == aiex_pkg::OP_DEC_SKIP_ZERO && n == 1) begin
         pc_m = pc_m + 10'h001;
         d = 1'b1;
      end
      // Zero flag and destination; memory rewritten with itself where untouched
      if (x.op inside {aiex_pkg::OP_OR_MEM, aiex_pkg::OP_OR_IMM, aiex_pkg::OP_DISJ_TO_MEM, aiex_pkg::OP_SUB_BORROW,
                       aiex_pkg::OP_SUB_BORROW_TO_MEM}) z_m = (r == 8'h00);
      if (x.op inside {aiex_pkg::OP_OR_MEM, aiex_pkg::OP_OR_IMM, aiex_pkg::OP_ROT_LEFT_TO_ACC, aiex_pkg::OP_SUB_BORROW,
                       aiex_pkg::OP_ROT_LEFT_VIA_CARRY_TO_ACC, aiex_pkg::OP_ROT_RIGHT_TO_ACC,
                       aiex_pkg::OP_ROT_RIGHT_VIA_CARRY_TO_ACC}) acc_m = r;
      else if (x.op != aiex_pkg::OP_STORE_ACC) mem_m[x.addr] = r;
   endtask : model

   // Predict, execute, then compare timing and visible state
   task automatic run(input aiex_pkg::aiex_op_t o, input logic [4:0] a, input logic [31:0] v);
      aiex_pkg::aiex_instr_t x;
      int n;
      int en;
      logic d;
      logic ed;
      x = '{op: o, addr: a, target: v[17:8], imm: v[7:0]};
      model(x, en, ed);
      exec(x, n, d);
      check("cycles", 33'(n), 33'(en));
      check("discard", {32'h0, d}, {32'h0, ed});
      check("irq enable", {32'h0, global_irq_enable}, {32'h0, g_m});
      check("pc port", {23'h0, pc}, {23'h0, pc_m});
      rd(aiex_pkg::REG_PC, {23'h0, pc_m});
      rd(aiex_pkg::REG_ACC, {25'h0, acc_m});
      rd(aiex_pkg::REG_STATUS, {28'h0, g_m, v_m, z_m, h_m, c_m});
   endtask : run

   // Each completed read is compared with the oldest note
   always @(posedge mclk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) check("apb read", {pslverr, prdata}, note_q.pop_front());
   end

   // Watchdog against a hang
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      instr_valid = 1'b0;
      instr = '0;
      acc_m = 8'h00;
      {g_m, v_m, z_m, h_m, c_m} = 5'h00;
      pc_m = 10'h000;
      stk_m = 10'h000;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      // Reset values, refused accesses and run enable
      rd(aiex_pkg::REG_STATUS, 33'h0);
      rd(aiex_pkg::REG_STACK, 33'h0);
      rd(aiex_pkg::REG_CTRL, 33'h0);
      rd(8'h14, 33'h100000000);
      apb(1'b1, aiex_pkg::REG_PC, 32'h155);
      rd(aiex_pkg::REG_PC, 33'h0);
      apb(1'b1, aiex_pkg::REG_CTRL, 32'h1);
      apb(1'b1, aiex_pkg::REG_ACC, 32'h5a);
      acc_m = 8'h5a;
      rd(aiex_pkg::REG_ACC, 33'h5a);
      // Known memory contents
      for (int k = 0; k < 32; k++) begin
         w = $random(seed);
         run(aiex_pkg::OP_LOAD_IMM, 5'h00, w);
         run(aiex_pkg::OP_STORE_ACC, 5'(k), w);
      end
      // Taken then untaken decrement skip, call and exit with constant
      run(aiex_pkg::OP_LOAD_IMM, 5'h03, 32'h01);
      run(aiex_pkg::OP_STORE_ACC, 5'h03, 32'h0);
      run(aiex_pkg::OP_DEC_SKIP_ZERO, 5'h03, 32'h0);
      run(aiex_pkg::OP_DEC_SKIP_ZERO, 5'h03, 32'h0);
      run(aiex_pkg::OP_CALL, 5'h00, 32'h2a700);
      rd(aiex_pkg::REG_STACK, {23'h0, stk_m});
      run(aiex_pkg::OP_SUB_EXIT_IMM, 5'h00, 32'hc3);
      // Random instructions with occasional flag preload
      for (int k = 0; k < 300; k++) begin
         w = $random(seed);
         if (w[31:30] == 2'b00) begin
            apb(1'b1, aiex_pkg::REG_STATUS, {27'h0, g_m, w[3:0]});
            {v_m, z_m, h_m, c_m} = w[3:0];
         end
         run(aiex_pkg::aiex_op_t'(5'(w[29:20] % 22)), w[22:18], w);
      end
      // Read back every memory byte
      for (int k = 0; k < 32; k++) run(aiex_pkg::OP_COPY_TO_ACC, 5'(k), 32'h0);
      @(posedge mclk);
      stop_test();
   end
endmodule : accumulator_instruction_exec_bench
